/* File: hw/bpd_map.svh */
`ifndef BPD_MAP_SVH
`define BPD_MAP_SVH
// Overview of operation
// [RULE1] configuration cycles are answered only while select line 20 is high
// [RULE2] command bit 2 enables mastering; clear stops moving data
// [RULE3] command bit 1 enables host memory writes to the table
// [RULE4] both enable bits come up set after reset
// [RULE5] table holds 1024 words at memory base plus four times channel
// [RULE6] host loads each used channel entry with its landing address
// [RULE7] backplane addresses with bits 31:10 all zero hit a channel
// [RULE8] a hit stores 128 data bits and 10 channel bits in the fifo
// [RULE9] a captured write is always answered with the low done strobe
// [RULE10] when the fifo is full writes are still answered and dropped
// [RULE11] non-empty fifo with mastering on requests the bus and writes
// [RULE12] head channel indexes the table, whose word is the write address
// [RULE13] each word goes out as two 64-bit phases, low half first
// [RULE14] same channel at the next entry continues the burst
// [RULE15] on stop the burst ends, bus is released, then resumes
// [RULE16] the transaction ends when the fifo runs empty
// [RULE17] entry advances 16 bytes per word on bits 18:3 only
// [RULE18] host reads of an entry return its advanced value
// [RULE19] with mastering off backplane writes still fill the fifo
// [RULE20] optionally done is withheld while the fifo is full
// [RULE21] senders write to their assigned channel addresses
// [RULE22] data and channel travel together through the fifo
`define BPD_CFG_ID     8'h00
`define BPD_CFG_CMD    8'h04
`define BPD_CFG_CLS    8'h08
`define BPD_CFG_BAR    8'h10
`define BPD_CFG_INT    8'h3c
`define BPD_CMD_RST    2'h3
`define BPD_STAT_VAL   16'h0400
`define BPD_CLASS      16'h0601
`define BPD_INT_PIN    8'h01
`define BPD_BAR_W      20
`define BPD_CH_W       10
`define BPD_DATA_W     128
`define BPD_FIFO_DEPTH 4096
`define BPD_TB_DEPTH   1024
`define BPD_PCI_MEMWR  4'h7
`define BPD_STEP_PHASE 16'h0001
`define BPD_STEP_WORD  16'h0002
`endif

/* File: hw/bpd_pkg.sv */
`include "bpd_map.svh"
package bpd_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_REQ  = 3'h1,
    M_ADDR = 3'h2,
    M_DATA = 3'h3,
    M_TURN = 3'h4
  } bpd_mst_t;

  typedef enum logic {
    T_IDLE = 1'h0,
    T_DATA = 1'h1
  } bpd_tgt_t;

  typedef struct packed {
    bpd_mst_t               ms;
    bpd_tgt_t               ts;
    logic                   ack;
    logic                   fprev;
    logic                   fresh;
    logic                   hi;
    logic [1:0]             cmd;
    logic [`BPD_BAR_W-1:0]  bar;
    logic [7:0]             iline;
    logic [31:0]            maddr;
    logic                   t_wr;
    logic                   t_cfg;
    logic [`BPD_CH_W-1:0]   t_off;
    logic [63:0]            ad;
    logic [7:0]             cbe;
    logic                   ad_oe_n;
    logic                   m_oe_n;
    logic                   t_oe_n;
    logic                   req_n;
    logic                   frame_n;
    logic                   irdy_n;
    logic                   trdy_n;
    logic                   stop_n;
    logic                   devsel_n;
  } bpd_st_t;

  // advance address bits 18:3 only, upper bits kept
  function automatic logic [31:0] bpd_step(input logic [31:0] a,
                                           input logic [15:0] k);
    bpd_step = {a[31:19], a[18:3] + k, a[2:0]};
  endfunction : bpd_step
endpackage : bpd_pkg

/* File: hw/bpd_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface bpd_fifo_if #(parameter int W = 138);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  logic         nxt_valid;
  logic [W-1:0] nxt_data;
  modport user  (output wr_valid, wr_data, rd_ready,
                 input wr_ready, rd_valid, rd_data, nxt_valid, nxt_data);
  modport store (input wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data, nxt_valid, nxt_data);
endinterface : bpd_fifo_if
`default_nettype wire

/* File: hw/bpd_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module bpd_fifo #(
  parameter int W     = 138,
  parameter int DEPTH = 4096
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  bpd_fifo_if.store   f
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } bpd_fst_t;

  bpd_fst_t        q;
  bpd_fst_t        d;
  logic [W-1:0]    mem [DEPTH];
  logic            push;
  logic            pop;
  logic [AW-1:0]   rp1;

  // ---------------------------------------------------------------
  // flags and pointers
  // ---------------------------------------------------------------
  assign f.wr_ready  = (q.cnt != DEPTH[AW:0]);
  assign f.rd_valid  = (q.cnt != '0);
  assign f.nxt_valid = (q.cnt > (AW+1)'(1));
  assign rp1         = q.rp + AW'(1);
  assign f.rd_data   = mem[q.rp];
  assign f.nxt_data  = mem[rp1];
  assign push        = f.wr_valid & f.wr_ready;
  assign pop         = f.rd_ready & f.rd_valid;

  // next pointer and count
  always_comb begin
    d = q;
    if (push)
      d.wp = q.wp + AW'(1);
    if (pop)
      d.rp = rp1;
    if (push && !pop)
      d.cnt = q.cnt + (AW+1)'(1);
    else if (pop && !push)
      d.cnt = q.cnt - (AW+1)'(1);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  // storage, data and channel written as one word
  always_ff @(posedge clk) begin
    if (push)
      mem[q.wp] <= f.wr_data;
  end
endmodule : bpd_fifo
`default_nettype wire

/* File: hw/bpd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bpd_map.svh"
module bpd_top #(
  parameter logic [15:0] DEV_ID     = 16'h1111, // arbitrary value
  parameter logic [15:0] VEN_ID     = 16'h2222, // arbitrary value
  parameter logic [15:0] REV_ID     = 16'h0001, // arbitrary value
  parameter int          FIFO_DEPTH = `BPD_FIFO_DEPTH,
  parameter bit          STALL_FULL = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         bp_write,
  input  wire logic [31:0]  bp_addr,
  input  wire logic [127:0] backplane_word,
  output logic              write_done_n,
  input  wire logic         pci_idsel,
  input  wire logic         pci_gnt_n,
  output logic              pci_req_n,
  input  wire logic [63:0]  pci_ad_i,
  output logic [63:0]       pci_ad_o,
  output logic              pci_ad_oe_n,
  input  wire logic [7:0]   pci_cbe_i,
  output logic [7:0]        pci_cbe_o,
  output logic              pci_mst_oe_n,
  input  wire logic         pci_frame_n_i,
  output logic              pci_frame_n_o,
  input  wire logic         pci_irdy_n_i,
  output logic              pci_irdy_n_o,
  input  wire logic         pci_trdy_n_i,
  output logic              pci_trdy_n_o,
  input  wire logic         pci_stop_n_i,
  output logic              pci_stop_n_o,
  output logic              pci_devsel_n_o,
  output logic              pci_tgt_oe_n
);
  localparam int CW = `BPD_CH_W;
  localparam int DW = `BPD_DATA_W;
  localparam int FW = DW + CW;

  localparam bpd_pkg::bpd_st_t RST = '{
    ms: bpd_pkg::M_IDLE, ts: bpd_pkg::T_IDLE,
    cmd: `BPD_CMD_RST, fresh: 1'b1, fprev: 1'b1,
    ad_oe_n: 1'b1, m_oe_n: 1'b1, t_oe_n: 1'b1,
    req_n: 1'b1, frame_n: 1'b1, irdy_n: 1'b1,
    trdy_n: 1'b1, stop_n: 1'b1, devsel_n: 1'b1,
    default: '0
  };

  logic [1:0]         rsync_q;
  logic               rst_n;
  bpd_pkg::bpd_st_t   q;
  bpd_pkg::bpd_st_t   d;
  logic [31:0]        tb_mem [`BPD_TB_DEPTH];
  logic               tb_we;
  logic [CW-1:0]      tb_wa;
  logic [31:0]        tb_wd;
  logic [31:0]        tb_head;
  logic [31:0]        tb_host;
  logic [CW-1:0]      head_ch;
  logic [DW-1:0]      head_dat;
  logic               bme;
  logic               mse;
  logic               cont_ok;
  logic               bp_hit;
  logic               own_bus;
  logic               cfg_hit;
  logic               mem_hit;
  logic [31:0]        rv;

  bpd_fifo_if #(.W(FW)) fq ();

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rsync_q <= 2'b00;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];

  // ---------------------------------------------------------------
  // input buffer
  // ---------------------------------------------------------------
  bpd_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .f     (fq)
  );

  // ---------------------------------------------------------------
  // translation table
  // ---------------------------------------------------------------
  // one write port shared by master advance and host writes
  always_ff @(posedge clk) begin
    if (tb_we)
      tb_mem[tb_wa] <= tb_wd;
  end

  // [RULE12] head channel lookup
  assign head_ch  = fq.rd_data[FW-1:DW];
  assign head_dat = fq.rd_data[DW-1:0];
  assign tb_head  = tb_mem[head_ch];
  // [RULE18] host sees live entry
  assign tb_host  = tb_mem[pci_ad_i[CW+1:2]];

  // ---------------------------------------------------------------
  // decodes
  // ---------------------------------------------------------------
  // [RULE2] mastering gate
  assign bme = q.cmd[1];
  assign mse = q.cmd[0];

  // [RULE14] same channel follows
  assign cont_ok = bme && fq.nxt_valid &&
                   (fq.nxt_data[FW-1:DW] == head_ch);

  // [RULE7] channel window hit
  assign bp_hit = bp_write && (bp_addr[31:CW] == '0) && !q.ack;

  assign own_bus = (q.ms == bpd_pkg::M_ADDR) ||
                   (q.ms == bpd_pkg::M_DATA) ||
                   (q.ms == bpd_pkg::M_TURN);

  // [RULE1] select line gates config
  assign cfg_hit = pci_idsel && (pci_cbe_i[3:1] == 3'b101) &&
                   (pci_ad_i[1:0] == 2'b00);

  // [RULE3] memory space gate
  assign mem_hit = mse && (pci_cbe_i[3:1] == 3'b011) &&
                   (pci_ad_i[31:32-`BPD_BAR_W] == q.bar);

  // configuration read mux
  always_comb begin
    unique case (pci_ad_i[7:0])
      `BPD_CFG_ID:  rv = {DEV_ID, VEN_ID};
      `BPD_CFG_CMD: rv = {`BPD_STAT_VAL, 13'h0000, q.cmd, 1'b0};
      `BPD_CFG_CLS: rv = {`BPD_CLASS, REV_ID};
      `BPD_CFG_BAR: rv = {q.bar, 12'h000};
      `BPD_CFG_INT: rv = {16'h0000, `BPD_INT_PIN, q.iline};
      default:      rv = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // backplane capture
  // ---------------------------------------------------------------
  // [RULE8] store word and channel
  assign fq.wr_valid = bp_hit;
  // [RULE22] one word per pair
  assign fq.wr_data  = {bp_addr[CW-1:0], backplane_word};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    tb_we       = 1'b0;
    tb_wa       = head_ch;
    tb_wd       = bpd_pkg::bpd_step(tb_head, `BPD_STEP_WORD);
    fq.rd_ready = 1'b0;
    d.fprev     = pci_frame_n_i;

    // [RULE9] done after capture
    if (bp_hit && (fq.wr_ready || !STALL_FULL))
      d.ack = 1'b1;   // [RULE10] full drops, still done
    else if (!bp_write)
      d.ack = 1'b0;   // [RULE20] held while full if stalling
    // [RULE19] capture never waits on mastering

    // master engine
    unique case (q.ms)
      bpd_pkg::M_IDLE: begin
        // [RULE11] request when data waits
        if (fq.rd_valid && bme) begin
          d.ms    = bpd_pkg::M_REQ;
          d.req_n = 1'b0;
        end
      end
      bpd_pkg::M_REQ: begin
        if (!bme) begin
          d.ms    = bpd_pkg::M_IDLE;
          d.req_n = 1'b1;
        end else if (!pci_gnt_n && pci_frame_n_i && pci_irdy_n_i &&
                     q.ts == bpd_pkg::T_IDLE &&
                     !(!pci_frame_n_i && q.fprev)) begin
          // [RULE12] table word as address
          d.maddr   = q.fresh ? tb_head : q.maddr;
          d.ad      = {32'h0000_0000, d.maddr};
          d.fresh   = 1'b0;
          d.ms      = bpd_pkg::M_ADDR;
          d.cbe     = {4'h0, `BPD_PCI_MEMWR};
          d.frame_n = 1'b0;
          d.m_oe_n  = 1'b0;
          d.ad_oe_n = 1'b0;
          d.req_n   = 1'b1;
        end
      end
      bpd_pkg::M_ADDR: begin
        // [RULE13] low half first
        d.ms      = bpd_pkg::M_DATA;
        d.ad      = q.hi ? head_dat[DW-1:64] : head_dat[63:0];
        d.cbe     = 8'h00;
        d.irdy_n  = 1'b0;
        d.frame_n = q.hi && !cont_ok;
      end
      bpd_pkg::M_DATA: begin
        if (!pci_trdy_n_i) begin
          d.maddr = bpd_pkg::bpd_step(q.maddr, `BPD_STEP_PHASE);
          d.hi    = !q.hi;
          if (q.hi) begin
            // [RULE17] advance entry 16 bytes
            tb_we       = 1'b1;
            fq.rd_ready = 1'b1;
            d.fresh     = 1'b1;
          end
          if (!pci_stop_n_i || q.frame_n || (q.hi && !cont_ok)) begin
            // [RULE16] end on stop or when no same-channel word follows
            d.ms      = bpd_pkg::M_TURN;
            d.frame_n = 1'b1;
            d.irdy_n  = 1'b1;
          end else if (q.hi) begin
            // [RULE14] burst continues
            d.ad      = fq.nxt_data[63:0];
            d.frame_n = 1'b0;
          end else begin
            // [RULE13] then high half
            d.ad      = head_dat[DW-1:64];
            d.frame_n = !cont_ok;
          end
        end else if (!pci_stop_n_i) begin
          // [RULE15] release and retry
          d.ms      = bpd_pkg::M_TURN;
          d.frame_n = 1'b1;
          d.irdy_n  = 1'b1;
        end
      end
      bpd_pkg::M_TURN: begin
        // [RULE15] let go, arbitrate again
        d.ms      = bpd_pkg::M_IDLE;
        d.m_oe_n  = 1'b1;
        d.ad_oe_n = 1'b1;
      end
      default: begin
        d.ms = bpd_pkg::M_IDLE;
      end
    endcase

    // target side
    unique case (q.ts)
      bpd_pkg::T_IDLE: begin
        if (!pci_frame_n_i && q.fprev && !own_bus &&
            (cfg_hit || mem_hit)) begin
          d.ts       = bpd_pkg::T_DATA;
          d.t_wr     = pci_cbe_i[0];
          d.t_cfg    = cfg_hit;
          d.t_off    = pci_ad_i[CW+1:2];
          d.devsel_n = 1'b0;
          d.trdy_n   = 1'b0;
          d.stop_n   = 1'b0;
          d.t_oe_n   = 1'b0;
          if (!pci_cbe_i[0]) begin
            d.ad      = {32'h0000_0000, cfg_hit ? rv : tb_host};
            d.ad_oe_n = 1'b0;
          end
        end
      end
      bpd_pkg::T_DATA: begin
        if (!pci_irdy_n_i) begin
          if (q.t_wr && q.t_cfg) begin
            // [RULE2] software sets enables
            if (q.t_off[5:0] == `BPD_CFG_CMD >> 2 && !pci_cbe_i[0])
              d.cmd = pci_ad_i[2:1];
            if (q.t_off[5:0] == `BPD_CFG_BAR >> 2 && !pci_cbe_i[3])
              d.bar = pci_ad_i[31:32-`BPD_BAR_W];
            if (q.t_off[5:0] == `BPD_CFG_INT >> 2 && !pci_cbe_i[0])
              d.iline = pci_ad_i[7:0];
          end else if (q.t_wr && mse) begin
            // [RULE5] host fills entry n
            tb_we = 1'b1;
            tb_wa = q.t_off;
            tb_wd = pci_ad_i[31:0];
          end
          d.ts       = bpd_pkg::T_IDLE;
          d.devsel_n = 1'b1;
          d.trdy_n   = 1'b1;
          d.stop_n   = 1'b1;
          d.t_oe_n   = 1'b1;
          d.ad_oe_n  = 1'b1;
        end
      end
      default: begin
        d.ts = bpd_pkg::T_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // [RULE4] enables set out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      q <= RST;
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign write_done_n   = !q.ack;
  assign pci_req_n      = q.req_n;
  assign pci_ad_o       = q.ad;
  assign pci_ad_oe_n    = q.ad_oe_n;
  assign pci_cbe_o      = q.cbe;
  assign pci_mst_oe_n   = q.m_oe_n;
  assign pci_frame_n_o  = q.frame_n;
  assign pci_irdy_n_o   = q.irdy_n;
  assign pci_trdy_n_o   = q.trdy_n;
  assign pci_stop_n_o   = q.stop_n;
  assign pci_devsel_n_o = q.devsel_n;
  assign pci_tgt_oe_n   = q.t_oe_n;
endmodule : bpd_top
`default_nettype wire

/* File: test/bpd_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module bpd_top_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        bp_write,
  input wire logic [31:0] bp_addr,
  input wire logic        write_done_n,
  input wire logic        pci_idsel,
  input wire logic        pci_gnt_n,
  input wire logic        pci_req_n,
  input wire logic        pci_ad_oe_n,
  input wire logic [7:0]  pci_cbe_i,
  input wire logic [7:0]  pci_cbe_o,
  input wire logic        pci_mst_oe_n,
  input wire logic        pci_frame_n_i,
  input wire logic        pci_frame_n_o,
  input wire logic        pci_irdy_n_i,
  input wire logic        pci_irdy_n_o,
  input wire logic        pci_trdy_n_i,
  input wire logic        pci_stop_n_i,
  input wire logic        pci_trdy_n_o,
  input wire logic        pci_stop_n_o,
  input wire logic        pci_devsel_n_o
);
  // ------
  // backplane side
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_hit_ack;
    $rose(bp_write) && bp_addr[31:10] == 22'h0 |=> !write_done_n;
  endproperty
  a_hit_ack: assert property (p_hit_ack)
    else $error("channel write not answered");
  property p_miss;
    bp_write && bp_addr[31:10] != 22'h0 |=> write_done_n;
  endproperty
  a_miss: assert property (p_miss)
    else $error("non channel write answered");
  property p_done_src;
    $fell(write_done_n) |-> $past(bp_write) && $past(bp_addr[31:10]) == 22'h0;
  endproperty
  a_done_src: assert property (p_done_src)
    else $error("done without channel write");
  property p_done_hold;
    !write_done_n && bp_write |=> !write_done_n;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done dropped early");
  // ------
  // pci side
  // ------
  // grant starts write
  property p_grant;
    !pci_req_n && !pci_gnt_n && pci_frame_n_i && pci_irdy_n_i |=>
      !pci_frame_n_o && !pci_mst_oe_n && !pci_ad_oe_n && pci_cbe_o[3:0] == 4'h7;
  endproperty
  a_grant: assert property (p_grant)
    else $error("no memory write after grant");
  property p_two_phase;
    $fell(pci_frame_n_o) |=> !pci_irdy_n_o && !pci_frame_n_o && pci_cbe_o[3:0] == 4'h0;
  endproperty
  a_two_phase: assert property (p_two_phase)
    else $error("address not followed by data");
  property p_last;
    !pci_irdy_n_o && pci_frame_n_o && !pci_trdy_n_i |=> pci_irdy_n_o;
  endproperty
  a_last: assert property (p_last)
    else $error("burst not ended");
  property p_stop;
    !pci_irdy_n_o && !pci_stop_n_i && pci_trdy_n_i |=>
      pci_frame_n_o && pci_irdy_n_o ##[1:6] !pci_req_n;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop not honoured");
  property p_claim;
    $fell(pci_devsel_n_o) |-> $past(pci_frame_n_i, 2) && !$past(pci_frame_n_i)
      && ($past(pci_idsel) || $past(pci_cbe_i[3:1]) == 3'b011);
  endproperty
  a_claim: assert property (p_claim)
    else $error("target claimed wrongly");
  property p_single;
    !pci_devsel_n_o && !pci_irdy_n_i |=>
      pci_devsel_n_o && pci_trdy_n_o && pci_stop_n_o;
  endproperty
  a_single: assert property (p_single)
    else $error("target held too long");
endmodule : bpd_top_asserts

bind bpd_top bpd_top_asserts u_chk (.clk, .resetn, .bp_write, .bp_addr,
  .write_done_n, .pci_idsel, .pci_gnt_n, .pci_req_n, .pci_ad_oe_n,
  .pci_cbe_i, .pci_cbe_o, .pci_mst_oe_n, .pci_frame_n_i, .pci_frame_n_o,
  .pci_irdy_n_i, .pci_irdy_n_o, .pci_trdy_n_i, .pci_stop_n_i,
  .pci_trdy_n_o, .pci_stop_n_o, .pci_devsel_n_o);
`default_nettype wire

/* File: test/bpd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bpd_mem_model (
  input wire logic        clk,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic [63:0] ad,
  input wire logic [7:0]  cbe,
  input wire logic [3:0]  stop_at,
  output logic            trdy_n,
  output logic            stop_n,
  output logic            devsel_n
);
  logic        act;
  logic        pf;
  logic [31:0] pa;
  int          n;
  logic [31:0] q_a[$];
  logic [63:0] q_d[$];

  // lines idle at their pull-up level
  initial begin
    {act, pf, trdy_n, stop_n, devsel_n} = 5'h0f;
  end

  // memory target: first phase waits a cycle, stop after stop_at phases
  always @(posedge clk) begin
    pf <= frame_n;
    if (!act) begin
      if (pf && !frame_n && cbe[3:0] == 4'h7 && ad[31:30] == 2'b01) begin
        act      <= 1'b1;
        pa       <= ad[31:0];
        n        <= 0;
        devsel_n <= 1'b0;
      end
    end else if (!stop_n || (frame_n && irdy_n)) begin
      {act, trdy_n, stop_n, devsel_n} <= 4'h7;
    end else if (!trdy_n && !irdy_n) begin
      q_a.push_back(pa);
      q_d.push_back(ad);
      pa <= pa + 32'h8;
      n  <= n + 1;
      if (frame_n) begin
        {act, trdy_n, stop_n, devsel_n} <= 4'h7;
      end else if (n + 1 == int'(stop_at)) begin
        trdy_n <= 1'b1;
        stop_n <= 1'b0;
      end
    end else begin
      trdy_n <= 1'b0;
    end
  end
endmodule : bpd_mem_model
`default_nettype wire

/* File: test/tb_backplane_to_pci_dma.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_backplane_to_pci_dma;
  localparam logic [15:0] DEV = 16'h1a2b; // arbitrary value
  localparam logic [15:0] VEN = 16'h3c4d; // arbitrary value
  localparam logic [15:0] REV = 16'h0005; // arbitrary value
  logic         clk, resetn, bp_write, pci_idsel, h_busy, h_frame, h_irdy;
  logic         write_done_n, pci_req_n, pci_ad_oe_n, pci_mst_oe_n, hit;
  logic         pci_frame_n_o, pci_irdy_n_o, pci_trdy_n_o, pci_stop_n_o;
  logic         pci_devsel_n_o, pci_tgt_oe_n, m_trdy, m_stop;
  logic [3:0]   stop_at;
  logic [7:0]   pci_cbe_o, h_cbe;
  logic [31:0]  bp_addr, rd;
  logic [63:0]  pci_ad_o, h_ad;
  logic [127:0] backplane_word;
  int           n_errors, num_checks, cyc;
  // ------
  // shared pci lines
  // ------
  wire logic        pci_gnt_n = pci_req_n | h_busy;
  wire logic [63:0] ad = !pci_ad_oe_n ? pci_ad_o : h_ad;
  wire logic [7:0]  cbe = !pci_mst_oe_n ? pci_cbe_o : h_cbe;
  wire logic        frame = !pci_mst_oe_n ? pci_frame_n_o : h_frame;
  wire logic        irdy = !pci_mst_oe_n ? pci_irdy_n_o : h_irdy;
  wire logic        trdy = !pci_tgt_oe_n ? pci_trdy_n_o : m_trdy;
  wire logic        stop = !pci_tgt_oe_n ? pci_stop_n_o : m_stop;

  bpd_top #(.DEV_ID(DEV), .VEN_ID(VEN), .REV_ID(REV), .FIFO_DEPTH(16)) dut (
    .clk, .resetn, .bp_write, .bp_addr, .backplane_word, .write_done_n,
    .pci_idsel, .pci_gnt_n, .pci_req_n, .pci_ad_i(ad), .pci_ad_o,
    .pci_ad_oe_n, .pci_cbe_i(cbe), .pci_cbe_o, .pci_mst_oe_n,
    .pci_frame_n_i(frame), .pci_frame_n_o, .pci_irdy_n_i(irdy),
    .pci_irdy_n_o, .pci_trdy_n_i(trdy), .pci_trdy_n_o, .pci_stop_n_i(stop),
    .pci_stop_n_o, .pci_devsel_n_o, .pci_tgt_oe_n);

  bpd_mem_model m (.clk(clk), .frame_n(frame), .irdy_n(irdy), .ad(ad),
    .cbe(cbe), .stop_at(stop_at), .trdy_n(m_trdy), .stop_n(m_stop),
    .devsel_n());

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  function automatic logic [127:0] wd(input logic [7:0] k);
    wd = {56'h1, k, 56'h2, k};
  endfunction : wd

  // host single-word cycle; bus granted to nobody else meanwhile
  task automatic host(input logic sel, input logic [3:0] c,
                      input logic [31:0] a, input logic [31:0] w);
    h_busy = 1'b1;
    hit = 1'b0;
    rd = 32'h0;
    tick();
    {h_frame, pci_idsel, h_ad, h_cbe} = {1'b0, sel, 32'h0, a, 4'h0, c};
    tick();
    {h_frame, h_irdy, h_cbe} = {2'b10, 8'h0};
    h_ad = c[0] ? {32'h0, w} : ~h_ad;
    for (int i = 0; i < 8 && !hit; i++) begin
      @(posedge clk);
      if (trdy === 1'b0) {hit, rd} = {1'b1, ad[31:0]};
      #1;
    end
    {h_irdy, pci_idsel, h_busy} = 3'h4;
    h_ad = ~h_ad;
  endtask : host

  task automatic mem(input logic [3:0] c, input logic [9:0] n,
                     input logic [31:0] w);
    host(1'b0, c, 32'h0200_0000 + {20'h0, n, 2'b00}, w);
  endtask : mem

  // sender write, held until done or for at most 6 cycles, then released
  task automatic bp(input logic [31:0] a, input logic [7:0] k,
                    input logic ack);
    logic seen;
    seen = 1'b0;
    {bp_write, bp_addr, backplane_word} = {1'b1, a, wd(k)};
    for (int i = 0; i < 6 && !seen; i++) begin
      @(posedge clk);
      seen = !write_done_n;
      #1;
    end
    chk("done", ack, seen);
    {bp_write, bp_addr, backplane_word} = ~{1'b1, a, wd(k)};
    for (int i = 0; i < 6 && !write_done_n; i++) tick();
  endtask : bp

  task automatic drain(input int n);
    for (int i = 0; i < 800 && m.q_d.size() < n; i++) tick();
    repeat (20) tick();
    chk("phase count", n, m.q_d.size());
  endtask : drain

  task automatic ph(input logic [31:0] a, input logic [63:0] d);
    chk("phase addr", a, m.q_a.pop_front());
    chk("phase data", d, m.q_d.pop_front());
  endtask : ph

  task automatic s_reset();
    host(1'b1, 4'ha, 32'h04, 32'h0);
    chk("command", {16'h0400, 2'b11}, {rd[31:16], rd[2:1]});
    host(1'b1, 4'ha, 32'h00, 32'h0);
    chk("ident", {DEV, VEN}, rd);
    host(1'b1, 4'ha, 32'h08, 32'h0);
    chk("class", {16'h0601, REV}, rd);
    host(1'b1, 4'ha, 32'h3c, 32'h0);
    chk("int pin", 8'h01, rd[15:8]);
    host(1'b1, 4'ha, 32'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    host(1'b0, 4'ha, 32'h04, 32'h0);
    chk("no select", 1'b0, hit);
  endtask : s_reset

  task automatic s_table();
    host(1'b1, 4'hb, 32'h10, 32'h0200_0000);
    mem(4'h7, 10'd1023, 32'h4020_0000);
    mem(4'h6, 10'd1023, 32'h0);
    chk("entry top", 32'h4020_0000, rd);
    host(1'b1, 4'hb, 32'h04, 32'h4);
    mem(4'h7, 10'd1023, 32'h1);
    chk("write refused", 1'b0, hit);
    host(1'b1, 4'hb, 32'h04, 32'h2);
    mem(4'h6, 10'd1023, 32'h0);
    chk("entry kept", 32'h4020_0000, rd);
  endtask : s_table

  task automatic s_fill();
    logic [127:0] w;
    mem(4'h7, 10'd0, 32'h4000_0000);
    bp(32'h0000_0400, 8'h0, 1'b0);
    for (int k = 0; k < 17; k++) bp(32'h0, 8'(k), 1'b1);
    chk("held back", 0, m.q_d.size());
    host(1'b1, 4'hb, 32'h04, 32'h6);
    drain(32);
    for (int k = 0; k < 32; k++) begin
      w = wd(8'(k / 2));
      ph(32'h4000_0000 + 32'(8 * k), k[0] ? w[127:64] : w[63:0]);
    end
    mem(4'h6, 10'd0, 32'h0);
    chk("entry 0", 32'h4000_0100, rd);
  endtask : s_fill

  task automatic s_stop();
    host(1'b1, 4'hb, 32'h04, 32'h2);
    mem(4'h7, 10'd5, 32'h4007_fff0);
    mem(4'h7, 10'd1023, 32'h4020_0000);
    stop_at = 4'd2;
    bp(32'h5, 8'h10, 1'b1);
    bp(32'h5, 8'h11, 1'b1);
    bp(32'h3ff, 8'h12, 1'b1);
    host(1'b1, 4'hb, 32'h04, 32'h6);
    drain(6);
    ph(32'h4007_fff0, {56'h2, 8'h10});
    ph(32'h4007_fff8, {56'h1, 8'h10});
    ph(32'h4000_0000, {56'h2, 8'h11});
    ph(32'h4000_0008, {56'h1, 8'h11});
    ph(32'h4020_0000, {56'h2, 8'h12});
    ph(32'h4020_0008, {56'h1, 8'h12});
    mem(4'h6, 10'd5, 32'h0);
    chk("entry 5", 32'h4000_0010, rd);
    mem(4'h6, 10'd1023, 32'h0);
    chk("entry top", 32'h4020_0010, rd);
  endtask : s_stop

  // main sequence
  initial begin
    {resetn, bp_write, pci_idsel, h_busy, bp_addr, backplane_word} = '0;
    {h_frame, h_irdy, h_ad, h_cbe, stop_at} = {2'b11, 64'h0, 8'h0, 4'h0};
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (3) tick();
    s_reset();
    s_table();
    s_fill();
    s_stop();
    results();
  end
endmodule : tb_backplane_to_pci_dma
`default_nettype wire
